/* File: dv/pms_mac_model.sv */
// behavioural MAC partner: pin pulls and receive sampling
`timescale 1ns/1ps
module pms_mac_model (
    input wire rx_clk,
    input wire rx_d0,
    input wire d2_o,
    input wire d2_oe,
    input wire [4:0] pin_o,
    input wire [4:0] pin_oe,
    input wire [4:0] strap,
    output wire [4:0] pin_i,
    output reg [3:0] got_d,
    output reg got_dv
);
    // released pins fall to the board resistor, i.e. the strap level
    assign pin_i = (pin_oe & pin_o) | (~pin_oe & strap);
    // sampled mid-bit so launch skew on the rising edge cannot race
    always @(negedge rx_clk) begin
        got_d <= {pin_i[1], d2_oe ? d2_o : 1'h1, pin_i[2], rx_d0};
        got_dv <= pin_i[0];
    end
endmodule // pms_mac_model

/* File: dv/pms_side_props.sv */
// assertion checker for the MAC-side status and strap block
`timescale 1ns/1ps
module pms_side_props (
    input wire CLK,
    input wire RST_B,
    input wire MED_RX_BUSY,
    input wire MED_TX_BUSY,
    input wire LINK_10M,
    input wire TRAFFIC,
    input wire RX_D0,
    input wire RX_D2_O,
    input wire RX_DV_O,
    input wire RX_DV_OE,
    input wire CARRIER_SENSE,
    input wire COLLISION,
    input wire LINK_LAMP_SECOND_O,
    input wire [1:0] STATION_ADDR,
    input wire RMII_MODE,
    input wire TXCLK_DRIVE
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_B);
    a_dv_gates_data: assert property (!RMII_MODE && !RX_DV_O |-> !RX_D0)
        else $error("data not zero outside valid");
    a_crs_follows: assert property (!RMII_MODE && $past(!RMII_MODE)
        |-> CARRIER_SENSE == $past(MED_RX_BUSY))
        else $error("carrier sense off medium");
    a_rmii_merge: assert property (RMII_MODE && $past(RMII_MODE && MED_RX_BUSY)
        |-> CARRIER_SENSE)
        else $error("combined carrier missing");
    a_dv_pin_off: assert property (RMII_MODE |-> !RX_DV_OE)
        else $error("valid pin driven in rmii");
    a_col_needs_both: assert property (COLLISION |-> $past(MED_RX_BUSY && MED_TX_BUSY))
        else $error("collision without both media");
    a_irq_pull_low: assert property (RMII_MODE |-> !RX_D2_O)
        else $error("irq pin driven high");
    a_lamp_needs_link: assert property (LINK_LAMP_SECOND_O |-> $past(LINK_10M))
        else $error("lamp lit without link");
    a_lamp_steady: assert property ($past(LINK_10M && !TRAFFIC && RST_B)
        |-> LINK_LAMP_SECOND_O)
        else $error("lamp dark on quiet link");
    a_txclk_rmii: assert property (TXCLK_DRIVE |-> RMII_MODE)
        else $error("tx clock driven outside rmii");
    a_addr_kept: assert property (STATION_ADDR != 2'h0 |=> $stable(STATION_ADDR))
        else $error("station address moved");
endmodule // pms_side_props
bind pms_side pms_side_props u_props (.CLK, .RST_B, .MED_RX_BUSY, .MED_TX_BUSY, .LINK_10M,
    .TRAFFIC, .RX_D0, .RX_D2_O, .RX_DV_O, .RX_DV_OE, .CARRIER_SENSE, .COLLISION,
    .LINK_LAMP_SECOND_O, .STATION_ADDR, .RMII_MODE, .TXCLK_DRIVE);

/* File: dv/pms_side_tb_top.sv */
// self-checking bench for the MAC-side status and strap block
`timescale 1ns/1ps
`include "pms_regs.vh"
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
    $display("unexpected t=%0t got %h exp %h", $time, (a), (e)); end end
module pms_side_tb_top;
    reg CLK = 0, RST_B = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, RECOV_CLK = 0;
    reg [11:0] PADDR = 12'h000;
    reg [31:0] PWDATA = 32'h0, rd;
    reg [3:0] RXSYM_D = 4'h0, d;
    reg RXSYM_DV = 0, MED_RX_BUSY = 0, MED_TX_BUSY = 0, LINK_10M = 0, TRAFFIC = 0;
    reg IRQ_EVENT = 0, WAKE_EVENT = 0, er, v;
    reg [4:0] strap = 5'h00;
    wire [31:0] PRDATA;
    wire PREADY, PSLVERR, RX_CLK, RX_D0, RX_D1_O, RX_D1_OE, RX_D2_O, RX_D2_OE, RX_D3_O, RX_D3_OE;
    wire RX_DV_O, RX_DV_OE, CARRIER_SENSE, COLLISION, RMII_MODE, TXCLK_DRIVE, got_dv;
    wire LINK_LAMP_FIRST_O, LINK_LAMP_FIRST_OE, LINK_LAMP_SECOND_O, LINK_LAMP_SECOND_OE;
    wire [1:0] STATION_ADDR;
    wire [4:0] pin_i;
    wire [3:0] got_d;
    wire RX_D1_I = pin_i[2], RX_D3_I = pin_i[1], RX_DV_I = pin_i[0];
    wire LINK_LAMP_FIRST_I = pin_i[3], LINK_LAMP_SECOND_I = pin_i[4];
    integer fails = 0, tests_run = 0, seed = 6630, run, i, n;
    always #5 CLK = ~CLK;
    always #40 RECOV_CLK = ~RECOV_CLK;
    pms_side #(.BLINK_CYCLES(32'd8)) uut (.CLK, .RST_B, .PSEL, .PENABLE, .PWRITE, .PADDR,
        .PWDATA, .PRDATA, .PREADY, .PSLVERR, .RECOV_CLK, .RXSYM_D, .RXSYM_DV, .MED_RX_BUSY,
        .MED_TX_BUSY, .LINK_10M, .TRAFFIC, .IRQ_EVENT, .WAKE_EVENT, .RX_CLK, .RX_D0, .RX_D1_I,
        .RX_D1_O, .RX_D1_OE, .RX_D2_O, .RX_D2_OE, .RX_D3_I, .RX_D3_O, .RX_D3_OE, .RX_DV_I,
        .RX_DV_O, .RX_DV_OE, .CARRIER_SENSE, .COLLISION, .LINK_LAMP_FIRST_I,
        .LINK_LAMP_FIRST_O, .LINK_LAMP_FIRST_OE, .LINK_LAMP_SECOND_I, .LINK_LAMP_SECOND_O,
        .LINK_LAMP_SECOND_OE, .STATION_ADDR, .RMII_MODE, .TXCLK_DRIVE);
    pms_mac_model mac (.rx_clk(RX_CLK), .rx_d0(RX_D0), .d2_o(RX_D2_O), .d2_oe(RX_D2_OE),
        .pin_o({LINK_LAMP_SECOND_O, LINK_LAMP_FIRST_O, RX_D1_O, RX_D3_O, RX_DV_O}),
        .pin_oe({LINK_LAMP_SECOND_OE, LINK_LAMP_FIRST_OE, RX_D1_OE, RX_D3_OE, RX_DV_OE}),
        .strap(strap), .pin_i(pin_i), .got_d(got_d), .got_dv(got_dv));
    task apb(input w, input [11:0] a, input [31:0] wd);
        begin
            @(posedge CLK);
            PSEL <= 1;
            PWRITE <= w;
            PADDR <= a;
            PWDATA <= wd;
            @(posedge CLK);
            PENABLE <= 1;
            @(posedge CLK);
            while (PREADY !== 1'h1) @(posedge CLK);
            rd = PRDATA;
            er = PSLVERR;
            PSEL <= 0;
            PENABLE <= 0;
        end
    endtask
    task conclude;
        begin
            if (fails == 0 && tests_run > 0) $display("Run complete: PASS");
            else $display("Run complete: FAIL");
            $finish;
        end
    endtask
    // expected valid bit and nibble; data reads zero outside valid
    function [4:0] exp_rx(input dv, input [3:0] dd);
        exp_rx = {dv, dv ? dd : 4'h0};
    endfunction
    initial begin
        #100000;
        fails++;
        conclude;
    end
    // ------------------------------------------------------------
    // one pass in MII, one in RMII with wake pin pulled up
    // ------------------------------------------------------------
    initial begin
        for (run = 0; run < 2; run++) begin
            n = $random(seed);
            @(posedge CLK);
            strap <= {n[1], n[0] | run[0], run[0], n[2], run[0]};
            RST_B <= 0;
            repeat (2) @(posedge CLK);
            RST_B <= 1;
            repeat (110) @(posedge CLK);
            `CHK(STATION_ADDR, {strap[4], strap[3]})
            `CHK(RMII_MODE, run[0])
            `CHK(TXCLK_DRIVE, run[0] & ~strap[1])
            apb(0, `PMS_STRAP_OFS, 32'h0);
            `CHK(rd, {27'h0, strap})
            apb(1, 12'h010, 32'hFFFFFFFF);
            `CHK(er, 1'h1)
            for (i = 0; i < 10; i++) begin
                @(negedge RECOV_CLK);
                @(posedge CLK);
                d = $random(seed);
                v = (i % 3) != 0;
                RXSYM_D <= d;
                RXSYM_DV <= v;
                repeat (2) @(negedge RX_CLK);
                #1;
                if (run == 0) `CHK({got_dv, got_d}, exp_rx(v, d))
                else `CHK(got_d[1:0], v ? d[1:0] : 2'h0)
            end
            repeat (40) @(posedge CLK) begin
                n = $random(seed);
                MED_RX_BUSY <= n[0];
                MED_TX_BUSY <= n[1];
            end
            MED_RX_BUSY <= 1;
            MED_TX_BUSY <= 1;
            repeat (3) @(posedge CLK);
            `CHK(CARRIER_SENSE, 1'h1)
            `CHK(COLLISION, ~run[0])
            apb(1, `PMS_CTRL_OFS, 32'h7);
            repeat (3) @(posedge CLK);
            `CHK(COLLISION, 1'h0)
            MED_RX_BUSY <= 0;
            MED_TX_BUSY <= 0;
            LINK_10M <= 1;
            repeat (3) @(posedge CLK);
            `CHK(LINK_LAMP_SECOND_O, 1'h1)
            if (run == 0) `CHK(LINK_LAMP_FIRST_O, 1'h1)
            TRAFFIC <= 1;
            n = 0;
            repeat (40) @(posedge CLK) if (LINK_LAMP_SECOND_O !== 1'h1) n++;
            `CHK(n >= 16 && n <= 24, 1'h1)
            TRAFFIC <= 0;
            apb(0, `PMS_LINE_OFS, 32'h0);
            `CHK(rd, 32'h0000_0014)
            LINK_10M <= 0;
            if (run == 1) begin
                IRQ_EVENT <= 1;
                WAKE_EVENT <= 1;
                @(posedge CLK);
                IRQ_EVENT <= 0;
                WAKE_EVENT <= 0;
                repeat (3) @(posedge CLK);
                `CHK({RX_D2_OE, RX_D2_O}, 2'h2)
                `CHK({LINK_LAMP_FIRST_OE, LINK_LAMP_FIRST_O}, 2'h2)
                apb(1, `PMS_EVENT_OFS, 32'h3);
                repeat (2) @(posedge CLK);
                `CHK({RX_D2_OE, LINK_LAMP_FIRST_OE}, 2'h0)
            end
        end
        conclude;
    end
endmodule // pms_side_tb_top

/* File: hdl/pms_regs.vh */
// register map, field positions and timing counts of the MAC-side block
`ifndef PMS_REGS_VH
`define PMS_REGS_VH

// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define PMS_STRAP_OFS 12'h000
`define PMS_CTRL_OFS 12'h004
`define PMS_EVENT_OFS 12'h008
`define PMS_LINE_OFS 12'h00C

// ------------------------------------------------------------
// strap register fields
// ------------------------------------------------------------
`define PMS_ST_RMII 0
`define PMS_ST_TXCK 1
`define PMS_ST_WAKE 2
`define PMS_ST_ADR0 3
`define PMS_ST_ADR1 4

// ------------------------------------------------------------
// control register fields and reset value
// ------------------------------------------------------------
`define PMS_CT_FULL 0
`define PMS_CT_IRQEN 1
`define PMS_CT_WAKEEN 2
`define PMS_CTRL_RST 3'h6

// ------------------------------------------------------------
// event register fields (write one to clear)
// ------------------------------------------------------------
`define PMS_EV_IRQ 0
`define PMS_EV_WAKE 1

// ------------------------------------------------------------
// line status fields
// ------------------------------------------------------------
`define PMS_LN_RX 0
`define PMS_LN_TX 1
`define PMS_LN_LINK 2
`define PMS_LN_ACT 3
`define PMS_LN_DONE 4

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define PMS_CLK_MHZ 100
`define PMS_STRAP_NS 1000
`define PMS_STRAP_CYC ((`PMS_STRAP_NS * `PMS_CLK_MHZ) / 1000)
`define PMS_BLINK_MS 50
`define PMS_BLINK_CYC (`PMS_BLINK_MS * `PMS_CLK_MHZ * 1000)

`endif

/* File: hdl/pms_side.v */
// MAC-facing receive, status, lamp and strap logic with APB registers
//
// Behaviour
// RL1 - strap pins are sampled during reset window, latched levels configure block afterwards
// RL2 - lamp/wake strap 0 gives first lamp, 1 gives wake output needing pull-up
// RL3 - decoded receive symbols change on recovered clock rising edge, valid with RX_DV
// RL4 - MII mode presents four receive data bits on all four pins
// RL5 - RMII mode turns receive data bit 2 into open-drain interrupt request
// RL6 - receive data bit 3 strap: 0 drives RMII transmit clock, 1 accepts it
// RL7 - MII carrier sense high while receive medium busy, otherwise low
// RL8 - RMII mode merges carrier sense and data valid on one output
// RL9 - MII collision low in full duplex; half duplex high when both media busy
// RL10 - first lamp steady on 10Mbps link, blinks during activity
// RL11 - second lamp steady on 10Mbps link, blinks during activity
// RL12 - latched levels on the two lamp pins form station address bits 0 and 1
// RL13 - receive clock follows recovered clock: 25MHz at 100M, 2.5MHz at 10M
// RL14 - media mode strap: 0 selects MII, 1 selects RMII
// RL15 - interrupt request is active low, pulls line only while pending
// RL16 - pins leave strap sampling for outputs without disturbing captured configuration
`timescale 1ns/1ps
`include "pms_regs.vh"

module pms_side #(
    parameter [31:0] BLINK_CYCLES = `PMS_BLINK_CYC
) (
    input wire CLK,
    input wire RST_B,
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output reg PREADY,
    output reg PSLVERR,
    input wire RECOV_CLK,
    input wire [3:0] RXSYM_D,
    input wire RXSYM_DV,
    input wire MED_RX_BUSY,
    input wire MED_TX_BUSY,
    input wire LINK_10M,
    input wire TRAFFIC,
    input wire IRQ_EVENT,
    input wire WAKE_EVENT,
    output reg RX_CLK,
    output reg RX_D0,
    input wire RX_D1_I,
    output reg RX_D1_O,
    output reg RX_D1_OE,
    output reg RX_D2_O,
    output reg RX_D2_OE,
    input wire RX_D3_I,
    output reg RX_D3_O,
    output reg RX_D3_OE,
    input wire RX_DV_I,
    output reg RX_DV_O,
    output reg RX_DV_OE,
    output reg CARRIER_SENSE,
    output reg COLLISION,
    input wire LINK_LAMP_FIRST_I,
    output reg LINK_LAMP_FIRST_O,
    output reg LINK_LAMP_FIRST_OE,
    input wire LINK_LAMP_SECOND_I,
    output reg LINK_LAMP_SECOND_O,
    output reg LINK_LAMP_SECOND_OE,
    output reg [1:0] STATION_ADDR,
    output reg RMII_MODE,
    output reg TXCLK_DRIVE
);

    // ------------------------------------------------------------
    // constants
    // ------------------------------------------------------------
    localparam [31:0] STRAP_CYC = `PMS_STRAP_CYC;
    localparam NSYNC = 6;
    localparam SY_RCLK = 0;
    localparam SY_DV = 1;
    localparam SY_D1 = 2;
    localparam SY_D3 = 3;
    localparam SY_L1 = 4;
    localparam SY_L2 = 5;

    // ------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------
    function [2:0] reg_idx;
        input [11:0] a;
        begin
            case (a)
                `PMS_STRAP_OFS: reg_idx = 3'd1;
                `PMS_CTRL_OFS: reg_idx = 3'd2;
                `PMS_EVENT_OFS: reg_idx = 3'd3;
                `PMS_LINE_OFS: reg_idx = 3'd4;
                default: reg_idx = 3'd0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    wire [NSYNC-1:0] pin_raw;
    reg [NSYNC-1:0] s1_q;
    reg [NSYNC-1:0] s2_q;
    reg [NSYNC-1:0] s3_q;
    reg [NSYNC-1:0] stab_q;

    assign pin_raw = {LINK_LAMP_SECOND_I, LINK_LAMP_FIRST_I, RX_D3_I,
                      RX_D1_I, RX_DV_I, RECOV_CLK};

    genvar g;
    generate
        for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
            always @(posedge CLK or negedge RST_B) begin
                if (!RST_B) begin
                    s1_q[g] <= 1'b0;
                    s2_q[g] <= 1'b0;
                    s3_q[g] <= 1'b0;
                    stab_q[g] <= 1'b0;
                end else begin
                    s1_q[g] <= pin_raw[g];
                    s2_q[g] <= s1_q[g];
                    s3_q[g] <= s2_q[g];
                    // a change counts only once two stages agree
                    if (s2_q[g] == s3_q[g]) begin
                        stab_q[g] <= s3_q[g];
                    end
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------
    reg [7:0] strap_cnt_q;
    reg strap_done_q;
    reg st_rmii_q;
    reg st_txck_q;
    reg st_wake_q;
    reg [1:0] st_adr_q;

    // window long enough for the pull resistors to settle through the sync chain
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            strap_cnt_q <= 8'h00;
            strap_done_q <= 1'b0;
            st_rmii_q <= 1'b0;
            st_txck_q <= 1'b0;
            st_wake_q <= 1'b0;
            st_adr_q <= 2'h0;
        end else if (!strap_done_q) begin
            strap_cnt_q <= strap_cnt_q + 8'h01;
            if ({24'h00_0000, strap_cnt_q} == STRAP_CYC - 32'h0000_0001) begin
                strap_done_q <= 1'b1; // [RL1]
                st_rmii_q <= stab_q[SY_DV]; // [RL14]
                st_txck_q <= stab_q[SY_D3]; // [RL6]
                st_wake_q <= stab_q[SY_D1]; // [RL2]
                st_adr_q <= {stab_q[SY_L2], stab_q[SY_L1]}; // [RL12]
            end
        end
    end

    // ------------------------------------------------------------
    // recovered clock edge
    // ------------------------------------------------------------
    reg rclk_prev_q;
    wire rclk_rise;

    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rclk_prev_q <= 1'b0;
        end else begin
            rclk_prev_q <= stab_q[SY_RCLK];
        end
    end

    assign rclk_rise = stab_q[SY_RCLK] & ~rclk_prev_q;

    // ------------------------------------------------------------
    // control and event registers
    // ------------------------------------------------------------
    reg [2:0] ctrl_q;
    reg irq_pend_q;
    reg wake_pend_q;
    wire acc_w;
    wire [2:0] acc_idx;
    wire clr_irq;
    wire clr_wake;

    assign acc_idx = reg_idx(PADDR);
    assign acc_w = PSEL & PENABLE & PREADY & PWRITE;
    assign clr_irq = acc_w & (acc_idx == 3'd3) & PWDATA[`PMS_EV_IRQ];
    assign clr_wake = acc_w & (acc_idx == 3'd3) & PWDATA[`PMS_EV_WAKE];

    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            ctrl_q <= `PMS_CTRL_RST;
            irq_pend_q <= 1'b0;
            wake_pend_q <= 1'b0;
        end else begin
            if (acc_w && acc_idx == 3'd2) begin
                ctrl_q <= PWDATA[2:0];
            end
            // a new event wins over a clear in the same cycle
            if (IRQ_EVENT && ctrl_q[`PMS_CT_IRQEN]) begin
                irq_pend_q <= 1'b1;
            end else if (clr_irq) begin
                irq_pend_q <= 1'b0;
            end
            if (WAKE_EVENT && ctrl_q[`PMS_CT_WAKEEN]) begin
                wake_pend_q <= 1'b1;
            end else if (clr_wake) begin
                wake_pend_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // apb answer, one wait-free access phase
    // ------------------------------------------------------------
    reg [31:0] rd_d;

    always @* begin
        rd_d = 32'h0000_0000;
        case (acc_idx)
            3'd1: begin
                rd_d[`PMS_ST_RMII] = st_rmii_q;
                rd_d[`PMS_ST_TXCK] = st_txck_q;
                rd_d[`PMS_ST_WAKE] = st_wake_q;
                rd_d[`PMS_ST_ADR1:`PMS_ST_ADR0] = st_adr_q;
            end
            3'd2: rd_d[2:0] = ctrl_q;
            3'd3: rd_d[1:0] = {wake_pend_q, irq_pend_q};
            3'd4: begin
                rd_d[`PMS_LN_RX] = MED_RX_BUSY;
                rd_d[`PMS_LN_TX] = MED_TX_BUSY;
                rd_d[`PMS_LN_LINK] = LINK_10M;
                rd_d[`PMS_LN_ACT] = TRAFFIC;
                rd_d[`PMS_LN_DONE] = strap_done_q;
            end
            default: rd_d = 32'h0000_0000;
        endcase
    end

    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else if (PSEL && !PENABLE) begin
            PREADY <= 1'b1;
            PRDATA <= PWRITE ? 32'h0000_0000 : rd_d;
            PSLVERR <= (acc_idx == 3'd0);
        end else begin
            PREADY <= 1'b0;
            PSLVERR <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // lamp blink timer
    // ------------------------------------------------------------
    reg [31:0] blink_cnt_q;
    reg blink_ph_q;

    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            blink_cnt_q <= 32'h0000_0000;
            blink_ph_q <= 1'b0;
        end else if (!TRAFFIC) begin
            blink_cnt_q <= 32'h0000_0000;
            blink_ph_q <= 1'b0;
        end else if (blink_cnt_q >= BLINK_CYCLES - 32'h1) begin
            blink_cnt_q <= 32'h0000_0000;
            blink_ph_q <= ~blink_ph_q;
        end else begin
            blink_cnt_q <= blink_cnt_q + 32'h1;
        end
    end

    wire lamp_on;
    assign lamp_on = LINK_10M & ~(TRAFFIC & blink_ph_q); // [RL10] [RL11]

    // ------------------------------------------------------------
    // receive path, updated on recovered clock rising edges
    // ------------------------------------------------------------
    reg [3:0] rxd_q;
    reg rxdv_q;

    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rxd_q <= 4'h0;
            rxdv_q <= 1'b0;
            RX_CLK <= 1'b0;
        end else begin
            RX_CLK <= stab_q[SY_RCLK]; // [RL13]
            if (rclk_rise) begin
                rxdv_q <= RXSYM_DV; // [RL3]
                rxd_q <= RXSYM_DV ? RXSYM_D : 4'h0; // [RL3]
            end
        end
    end

    // ------------------------------------------------------------
    // pin drivers
    // ------------------------------------------------------------
    // enables stay off until straps are held, so no pin fights its pull
    always @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            RX_D0 <= 1'b0;
            RX_D1_O <= 1'b0;
            RX_D1_OE <= 1'b0;
            RX_D2_O <= 1'b0;
            RX_D2_OE <= 1'b0;
            RX_D3_O <= 1'b0;
            RX_D3_OE <= 1'b0;
            RX_DV_O <= 1'b0;
            RX_DV_OE <= 1'b0;
            CARRIER_SENSE <= 1'b0;
            COLLISION <= 1'b0;
            LINK_LAMP_FIRST_O <= 1'b0;
            LINK_LAMP_FIRST_OE <= 1'b0;
            LINK_LAMP_SECOND_O <= 1'b0;
            LINK_LAMP_SECOND_OE <= 1'b0;
            STATION_ADDR <= 2'h0;
            RMII_MODE <= 1'b0;
            TXCLK_DRIVE <= 1'b0;
        end else begin
            RX_D0 <= rxd_q[0];
            RX_D1_O <= rxd_q[1];
            RX_D1_OE <= strap_done_q; // [RL16]
            RX_DV_O <= rxdv_q;
            RX_DV_OE <= strap_done_q & ~st_rmii_q; // [RL16]
            STATION_ADDR <= st_adr_q; // [RL12]
            RMII_MODE <= st_rmii_q; // [RL14]
            TXCLK_DRIVE <= st_rmii_q & ~st_txck_q; // [RL6]
            if (!st_rmii_q) begin
                RX_D2_O <= rxd_q[2]; // [RL4]
                RX_D2_OE <= strap_done_q;
                RX_D3_O <= rxd_q[3]; // [RL4]
                RX_D3_OE <= strap_done_q;
                CARRIER_SENSE <= MED_RX_BUSY; // [RL7]
                COLLISION <= ~ctrl_q[`PMS_CT_FULL]
                    & MED_TX_BUSY & MED_RX_BUSY; // [RL9]
            end else begin
                // open drain: only ever pulls low
                RX_D2_O <= 1'b0; // [RL15]
                RX_D2_OE <= strap_done_q & irq_pend_q; // [RL5] [RL15]
                RX_D3_O <= 1'b0;
                RX_D3_OE <= 1'b0;
                CARRIER_SENSE <= MED_RX_BUSY | rxdv_q; // [RL8]
                COLLISION <= 1'b0;
            end
            if (st_wake_q) begin
                // wake pin relies on board pull-up for its high level
                LINK_LAMP_FIRST_O <= 1'b0; // [RL2]
                LINK_LAMP_FIRST_OE <= strap_done_q & wake_pend_q; // [RL2]
            end else begin
                LINK_LAMP_FIRST_O <= lamp_on; // [RL10]
                LINK_LAMP_FIRST_OE <= strap_done_q; // [RL16]
            end
            LINK_LAMP_SECOND_O <= lamp_on; // [RL11]
            LINK_LAMP_SECOND_OE <= strap_done_q; // [RL16]
        end
    end

endmodule // pms_side
